// File: verilog/ccvt_defs.svh
// Opcode, field and encoding constants for the compare and convert trap unit.
`ifndef CCVT_DEFS_SVH
`define CCVT_DEFS_SVH
`define CCVT_OP_MSB         31
`define CCVT_OP_LSB         24
`define CCVT_TGT_MSB        23
`define CCVT_TGT_LSB        16
`define CCVT_SRC1_MSB       15
`define CCVT_SRC1_LSB       8
`define CCVT_SRC2_MSB       7
`define CCVT_SRC2_LSB       0
`define CCVT_OP_LEU         7'h23
`define CCVT_OP_LT          7'h20
`define CCVT_OP_LTU         7'h21
`define CCVT_OP_NEQ         7'h31
`define CCVT_OP_D2S         8'hE9
`define CCVT_OP_D2I         8'hEA
`define CCVT_OP_S2D         8'hE8
`define CCVT_TRUE           32'h80000000
`define CCVT_FALSE          32'h00000000
`define CCVT_TRAP_D2S       2'h1
`define CCVT_TRAP_D2I       2'h2
`define CCVT_TRAP_S2D       2'h3
`define CCVT_TWIN_MASK      8'h01
`endif

// File: verilog/ccvt_pkg.sv
// Types shared by the compare and convert trap unit.
package ccvt_pkg;
   typedef enum logic [1:0] {
      CCVT_IDLE  = 2'h0,
      CCVT_WRITE = 2'h1,
      CCVT_TRAP  = 2'h3
   } ccvt_state_e;
endpackage

// File: verilog/ccvt_ptr_reg.sv
// Trap operand pointer registers loaded when a conversion trap is taken.
`timescale 1ns/1ps
`include "ccvt_defs.svh"
module ccvt_ptr_reg (
   input  wire logic       mclk_i,
   input  wire logic       rst_n_i,
   input  wire logic       load_i,
   input  wire logic [7:0] first_ptr_i,
   input  wire logic [7:0] second_ptr_i,
   input  wire logic [7:0] result_ptr_i,
   output logic      [7:0] first_ptr_o,
   output logic      [7:0] second_ptr_o,
   output logic      [7:0] result_ptr_o
);
   logic [7:0] next_first;
   logic [7:0] next_second;
   logic [7:0] next_result;

   always_comb begin
      next_first  = first_ptr_o;
      next_second = second_ptr_o;
      next_result = result_ptr_o;
      if (load_i) begin
         next_first  = first_ptr_i;
         next_second = second_ptr_i;
         next_result = result_ptr_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         first_ptr_o  <= 8'h00;
         second_ptr_o <= 8'h00;
         result_ptr_o <= 8'h00;
      end else begin
         first_ptr_o  <= next_first;
         second_ptr_o <= next_second;
         result_ptr_o <= next_result;
      end
   end
endmodule

// File: verilog/ccvt_unit.sv
// Decode and execute of integer compares and conversion traps.
`timescale 1ns/1ps
`include "ccvt_defs.svh"
module ccvt_unit (
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic        instr_valid_i,
   input  wire logic [31:0] instr_i,
   output logic      [7:0]  rd_first_addr_o,
   output logic      [7:0]  rd_second_addr_o,
   input  wire logic [31:0] rd_first_data_i,
   input  wire logic [31:0] rd_second_data_i,
   output logic             wr_en_o,
   output logic      [7:0]  wr_addr_o,
   output logic      [31:0] wr_data_o,
   output logic             trap_o,
   output logic      [1:0]  trap_kind_o,
   output logic      [7:0]  trap_first_operand_pointer_o,
   output logic      [7:0]  trap_second_operand_pointer_o,
   output logic      [7:0]  trap_result_pointer_o,
   output logic      [7:0]  trap_first_twin_o,
   output logic      [7:0]  trap_result_twin_o,
   output logic             unhandled_o
);
   logic [7:0]  opcode;
   logic [7:0]  target_field;
   logic [7:0]  first_source_field;
   logic [7:0]  second_source_field;
   logic        immediate_select_bit;
   logic [31:0] second_operand;
   logic        cond;
   logic        is_cmp;
   logic        is_conv;
   logic [1:0]  kind;
   ccvt_pkg::ccvt_state_e state;
   ccvt_pkg::ccvt_state_e next_state;
   logic [7:0]  next_wr_addr;
   logic [31:0] next_wr_data;
   logic        next_trap;
   logic [1:0]  next_trap_kind;
   logic        next_unhandled;

   assign opcode               = instr_i[`CCVT_OP_MSB:`CCVT_OP_LSB];
   assign target_field         = instr_i[`CCVT_TGT_MSB:`CCVT_TGT_LSB];
   assign first_source_field   = instr_i[`CCVT_SRC1_MSB:`CCVT_SRC1_LSB];
   assign second_source_field  = instr_i[`CCVT_SRC2_MSB:`CCVT_SRC2_LSB];
   assign immediate_select_bit = opcode[0];
   assign rd_first_addr_o      = first_source_field;
   assign rd_second_addr_o     = second_source_field;
   // Immediate is the raw low byte, widened with zeros.
   assign second_operand = immediate_select_bit ? {24'h000000, second_source_field}
                                                : rd_second_data_i;

   always_comb begin
      is_cmp  = 1'b1;
      is_conv = 1'b0;
      kind    = 2'h0;
      cond    = 1'b0;
      case (opcode[7:1])
         `CCVT_OP_LEU: cond = rd_first_data_i <= second_operand;
         `CCVT_OP_LT:  cond = $signed(rd_first_data_i) < $signed(second_operand);
         `CCVT_OP_LTU: cond = rd_first_data_i < second_operand;
         `CCVT_OP_NEQ: cond = rd_first_data_i != second_operand;
         default:      is_cmp = 1'b0;
      endcase
      case (opcode)
         `CCVT_OP_D2S: begin
            is_conv = 1'b1;
            kind    = `CCVT_TRAP_D2S;
         end
         `CCVT_OP_D2I: begin
            is_conv = 1'b1;
            kind    = `CCVT_TRAP_D2I;
         end
         `CCVT_OP_S2D: begin
            is_conv = 1'b1;
            kind    = `CCVT_TRAP_S2D;
         end
         default: kind = 2'h0;
      endcase
   end

   // Sequencing state; the write and trap pulses are decoded from it.
   always_comb begin
      next_state = ccvt_pkg::CCVT_IDLE;
      if (instr_valid_i) begin
         if (is_cmp) begin
            next_state = ccvt_pkg::CCVT_WRITE;
         end else if (is_conv) begin
            next_state = ccvt_pkg::CCVT_TRAP;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= ccvt_pkg::CCVT_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Both pulses come straight from the state flops, so each lasts one cycle.
   assign wr_en_o = (state == ccvt_pkg::CCVT_WRITE);
   assign trap_o  = (state == ccvt_pkg::CCVT_TRAP);

   // Address and data hold after the pulse so a slow far side may sample late.
   always_comb begin
      next_wr_addr = wr_addr_o;
      next_wr_data = wr_data_o;
      if (next_state == ccvt_pkg::CCVT_WRITE) begin
         next_wr_addr = target_field;
         next_wr_data = cond ? `CCVT_TRUE : `CCVT_FALSE;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_addr_o <= 8'h00;
         wr_data_o <= 32'h00000000;
      end else begin
         wr_addr_o <= next_wr_addr;
         wr_data_o <= next_wr_data;
      end
   end

   // No conversion datapath; software emulates it in the handler.
   always_comb begin
      next_trap      = (next_state == ccvt_pkg::CCVT_TRAP);
      next_trap_kind = trap_kind_o;
      if (next_trap) begin
         next_trap_kind = kind;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         trap_kind_o <= 2'h0;
      end else begin
         trap_kind_o <= next_trap_kind;
      end
   end

   // Opcodes outside this block are flagged so the pipeline can route them on.
   always_comb begin
      next_unhandled = instr_valid_i && !is_cmp && !is_conv;
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         unhandled_o <= 1'b0;
      end else begin
         unhandled_o <= next_unhandled;
      end
   end

   // The second pointer takes the raw low byte, which handlers must ignore.
   ccvt_ptr_reg u_ptr (
      .mclk_i       (mclk_i),
      .rst_n_i      (rst_n_i),
      .load_i       (next_trap),
      .first_ptr_i  (first_source_field),
      .second_ptr_i (second_source_field),
      .result_ptr_i (target_field),
      .first_ptr_o  (trap_first_operand_pointer_o),
      .second_ptr_o (trap_second_operand_pointer_o),
      .result_ptr_o (trap_result_pointer_o)
   );

   assign trap_first_twin_o  = trap_first_operand_pointer_o ^ `CCVT_TWIN_MASK;
   assign trap_result_twin_o = trap_result_pointer_o ^ `CCVT_TWIN_MASK;
endmodule

// File: verification/ccvt_unit_chk.sv
// Port checks for the compare and convert trap unit.
`timescale 1ns/1ps
`include "ccvt_defs.svh"
module ccvt_unit_chk (
   input wire logic        mclk_i,
   input wire logic        rst_n_i,
   input wire logic        instr_valid_i,
   input wire logic [31:0] instr_i,
   input wire logic [31:0] rd_first_data_i,
   input wire logic [31:0] rd_second_data_i,
   input wire logic        wr_en_o,
   input wire logic [7:0]  wr_addr_o,
   input wire logic [31:0] wr_data_o,
   input wire logic        trap_o,
   input wire logic [1:0]  trap_kind_o,
   input wire logic [7:0]  trap_first_operand_pointer_o,
   input wire logic [7:0]  trap_result_pointer_o,
   input wire logic [7:0]  trap_first_twin_o,
   input wire logic [7:0]  trap_result_twin_o
);
   logic [31:0] b;
   logic [6:0]  op;
   logic        leu, lt, ltu, ne, cmp;
   // Sentinel 7F is no compare, so an idle slot never arms a compare check.
   assign op = instr_valid_i ? instr_i[31:25] : 7'h7F;
   assign b = instr_i[24] ? {24'h000000, instr_i[7:0]} : rd_second_data_i;
   assign leu = rd_first_data_i <= b;
   assign lt = $signed(rd_first_data_i) < $signed(b);
   assign ltu = rd_first_data_i < b;
   assign ne = rd_first_data_i != b;
   assign cmp = op inside {`CCVT_OP_LEU, `CCVT_OP_LT, `CCVT_OP_LTU, `CCVT_OP_NEQ};
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   property p_leu; op == `CCVT_OP_LEU |=> wr_data_o == {$past(leu), 31'h00000000}; endproperty
   property p_lt; op == `CCVT_OP_LT |=> wr_data_o == {$past(lt), 31'h00000000}; endproperty
   property p_ltu; op == `CCVT_OP_LTU |=> wr_data_o[31] == $past(ltu); endproperty
   property p_neq; op == `CCVT_OP_NEQ |=> wr_data_o[31] == $past(ne); endproperty
   property p_one; cmp |=> wr_en_o && !trap_o && wr_addr_o == $past(instr_i[23:16]); endproperty
   property p_d2s; instr_valid_i && instr_i[31:24] == 8'hE9 |=> trap_o && trap_kind_o == 2'h1;
   endproperty
   property p_d2i; instr_valid_i && instr_i[31:24] == 8'hEA |=> trap_o && trap_kind_o == 2'h2;
   endproperty
   property p_s2d; instr_valid_i && instr_i[31:24] == 8'hE8 |=> !wr_en_o && trap_kind_o == 2'h3;
   endproperty
   property p_ptr; trap_o |-> trap_first_operand_pointer_o == $past(instr_i[15:8])
      && trap_result_pointer_o == $past(instr_i[23:16]); endproperty
   property p_twin; trap_o |-> trap_first_twin_o == ($past(instr_i[15:8]) ^ 8'h01)
      && trap_result_twin_o == ($past(instr_i[23:16]) ^ 8'h01); endproperty
   a_leu: assert property (p_leu) else $error("unsigned le result wrong");
   a_lt: assert property (p_lt) else $error("signed lt result wrong");
   a_ltu: assert property (p_ltu) else $error("unsigned lt result wrong");
   a_neq: assert property (p_neq) else $error("not equal result wrong");
   a_one: assert property (p_one) else $error("compare write wrong");
   a_d2s: assert property (p_d2s) else $error("double to single trap wrong");
   a_d2i: assert property (p_d2i) else $error("double to integer trap wrong");
   a_s2d: assert property (p_s2d) else $error("single to double trap wrong");
   a_ptr: assert property (p_ptr) else $error("trap pointers wrong");
   a_twin: assert property (p_twin) else $error("twin registers wrong");
   cover property (trap_o && trap_kind_o == 2'h2);
   cover property (wr_en_o && wr_data_o[31]);
   cover property (wr_en_o ##1 trap_o);
endmodule
bind ccvt_unit ccvt_unit_chk u_chk (.*);

// File: verification/ccvt_regfile_model.sv
// Register file behind the unit: same-cycle reads, clocked write-back.
`timescale 1ns/1ps
module ccvt_regfile_model (
   input  wire logic        mclk_i,
   input  wire logic        wr_en_i,
   input  wire logic [7:0]  wr_addr_i,
   input  wire logic [31:0] wr_data_i,
   input  wire logic [7:0]  rd_first_addr_i,
   input  wire logic [7:0]  rd_second_addr_i,
   output logic      [31:0] rd_first_data_o,
   output logic      [31:0] rd_second_data_o
);
   logic [31:0] regs [256];
   assign rd_first_data_o = regs[rd_first_addr_i];
   assign rd_second_data_o = regs[rd_second_addr_i];
   always @(posedge mclk_i) begin
      if (wr_en_i) regs[wr_addr_i] <= wr_data_i;
   end
endmodule

// File: verification/compare_and_convert_trap_unit_bench.sv
// Self-checking bench for the compare and convert trap unit.
`timescale 1ns/1ps
module compare_and_convert_trap_unit_bench;
   logic        clk = 1'b0, rst_n = 1'b0, vld = 1'b0, we, tp, uh;
   logic [31:0] ins = 32'h00000000, da, db, wd;
   logic [7:0]  ra, rb, wa, p1, p2, pr, t1, tr;
   logic [1:0]  tk;
   int          n_fail = 0, tests_run = 0;
   initial forever #20 clk = ~clk;
   ccvt_unit dut (.mclk_i(clk), .rst_n_i(rst_n), .instr_valid_i(vld), .instr_i(ins),
      .rd_first_addr_o(ra), .rd_second_addr_o(rb), .rd_first_data_i(da),
      .rd_second_data_i(db), .wr_en_o(we), .wr_addr_o(wa), .wr_data_o(wd), .trap_o(tp),
      .trap_kind_o(tk), .trap_first_operand_pointer_o(p1), .trap_second_operand_pointer_o(p2),
      .trap_result_pointer_o(pr), .trap_first_twin_o(t1), .trap_result_twin_o(tr),
      .unhandled_o(uh));
   ccvt_regfile_model m (.mclk_i(clk), .wr_en_i(we), .wr_addr_i(wa), .wr_data_i(wd),
      .rd_first_addr_i(ra), .rd_second_addr_i(rb), .rd_first_data_o(da), .rd_second_data_o(db));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic issue(input logic [31:0] i);
      @(negedge clk);
      vld = 1'b1;
      ins = i;
      @(negedge clk);
      vld = 1'b0;
   endtask
   task automatic cmp(input logic [7:0] op, input logic [15:0] src, input logic res);
      issue({op, 8'h10, src});
      chk({tp, we, wa}, {2'h1, 8'h10});
      chk(wd, {res, 31'h00000000});
      @(negedge clk);
      chk(we, 1'h0);
      chk(m.regs[16], {res, 31'h00000000});
   endtask
   task automatic t_compares;
      cmp(8'h46, 16'h0102, 1'h0);
      cmp(8'h46, 16'h0203, 1'h1);
      cmp(8'h47, 16'h0201, 1'h1);
      cmp(8'h40, 16'h0102, 1'h1);
      cmp(8'h41, 16'h0202, 1'h1);
      cmp(8'h42, 16'h0102, 1'h0);
      cmp(8'h43, 16'h02FF, 1'h1);
      cmp(8'h62, 16'h0203, 1'h0);
      cmp(8'h63, 16'h0203, 1'h1);
   endtask
   task automatic t_trap(input logic [7:0] op, input logic [1:0] kind);
      issue({op, 24'h07045A});
      chk({tp, we, tk}, {2'h2, kind});
      chk({p1, pr}, 16'h0407);
      chk({t1, tr}, 16'h0506);
      chk(p2, 8'h5A);
      @(negedge clk);
      chk(tp, 1'h0);
   endtask
   // Compare and trap on adjacent edges must not bleed into each other.
   task automatic t_back;
      @(negedge clk);
      vld = 1'b1;
      ins = 32'h62110102;
      @(negedge clk);
      ins = 32'hE8090200;
      chk({we, tp}, 2'h2);
      chk(wd, 32'h80000000);
      @(negedge clk);
      vld = 1'b0;
      chk({we, tp, tk, pr}, {4'h7, 8'h09});
   endtask
   // An opcode outside the block only pulses the flag and leaves the write side alone.
   task automatic t_unh;
      issue(32'h60100102);
      chk({uh, we, tp}, 3'h4);
      chk(wa, 8'h10);
      @(negedge clk);
      chk(uh, 1'h0);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      #20000;
      n_fail++;
      final_report;
   end
   initial begin
      m.regs[1] = 32'h80000000;
      m.regs[2] = 32'h00000001;
      m.regs[3] = 32'h00000001;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      t_compares;
      t_unh;
      t_trap(8'hE9, 2'h1);
      t_trap(8'hEA, 2'h2);
      t_trap(8'hE8, 2'h3);
      t_back;
      final_report;
   end
endmodule
